// ===== core/sat_regs.vh
// constants for the segment address translator
`ifndef SAT_REGS_VH
`define SAT_REGS_VH
`define SAT_SEG_W 7
`define SAT_OFS_W 16
`define SAT_PHY_W 24
`define SAT_BASE_W 16
`define SAT_IDX_W 6
`define SAT_LIM_W 8
`define SAT_ENTRIES 64
`define SAT_ENT_W 28
`define SAT_ENT_BASE_LSB 0
`define SAT_ENT_BASE_MSB 15
`define SAT_ENT_LIM_LSB 16
`define SAT_ENT_LIM_MSB 23
`define SAT_ENT_WP 24
`define SAT_ENT_SYS 25
`define SAT_ENT_EXO 26
`define SAT_ENT_VAL 27
`define SAT_ENT_RST 28'h0000000
`define SAT_GRP_W 1
`define SAT_PAGE_LSB 8
`define SAT_ZERO8 8'h00
`define SAT_PHY_RST 24'h000000
`endif

// ===== core/sat_table.v
// segment descriptor memory with registered read port
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_table (
    input wire i_clk,
    input wire i_ce,
    input wire i_we,
    input wire [`SAT_IDX_W-1:0] i_waddr,
    input wire [`SAT_ENT_W-1:0] i_wdata,
    input wire [`SAT_IDX_W-1:0] i_raddr,
    output reg [`SAT_ENT_W-1:0] o_rdata
);
    reg [`SAT_ENT_W-1:0] mem [0:`SAT_ENTRIES-1];
    always @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end
endmodule // sat_table

// ===== core/sat_translator.v
// segment address translator: table lookup, base plus offset, protection
// Functional notes
// RULE1: logical address is 7-bit segment and 16-bit offset; segment selects base
// RULE2: physical address is base plus offset by addition, never concatenation
// RULE3: segment numbers span 128 segments across cooperating units
// RULE4: segment size 256 bytes to 64 KB in 256-byte steps
// RULE5: table entries are rewritable at any time by the controller; the table here takes writes only while i_ce is high
// RULE6: per-segment attributes block writes to write-protected segments
// RULE7: system/normal and code/data qualifiers form separate spaces
// RULE8: several units may serve one processor together
// RULE9: each unit holds 64 segments; more units cover the rest
// RULE10: 24-bit physical address; bases are 256-byte multiples, may overlap
// RULE11: offset beyond limit or attribute breach flags violation, kills access
`timescale 1ns/10ps
`include "sat_regs.vh"
module sat_translator (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire [`SAT_GRP_W-1:0] i_unit_group,
    input wire i_req,
    input wire [`SAT_SEG_W-1:0] i_seg,
    input wire [`SAT_OFS_W-1:0] i_ofs,
    input wire i_write,
    input wire i_sys_space,
    input wire i_code_space,
    input wire i_tbl_we,
    input wire [`SAT_IDX_W-1:0] i_tbl_idx,
    input wire [`SAT_BASE_W-1:0] i_tbl_base,
    input wire [`SAT_LIM_W-1:0] i_tbl_limit,
    input wire i_tbl_wprot,
    input wire i_tbl_sys_only,
    input wire i_tbl_exec_only,
    input wire i_tbl_valid,
    output reg o_mem_req,
    output reg o_mem_write,
    output reg [`SAT_PHY_W-1:0] o_phys_addr,
    output reg o_violation,
    output reg o_hit
);
    // pipeline stage 1: request registered alongside table read
    reg s1_req;
    reg s1_mine;
    reg [`SAT_OFS_W-1:0] s1_ofs;
    reg s1_write;
    reg s1_sys;
    reg s1_code;
    wire [`SAT_ENT_W-1:0] ent;
    wire [`SAT_ENT_W-1:0] wr_ent;
    wire [`SAT_BASE_W-1:0] ent_base;
    wire [`SAT_LIM_W-1:0] ent_lim;
    wire over_lim;
    wire attr_bad;
    wire bad;
    wire [`SAT_PHY_W-1:0] next_phys;

    // top segment bit picks which unit answers; low six bits index the table
    wire mine = i_seg[`SAT_SEG_W-1] == i_unit_group; // [RULE3] [RULE8] [RULE9]

    assign wr_ent = {i_tbl_valid, i_tbl_exec_only, i_tbl_sys_only, i_tbl_wprot,
                     i_tbl_limit, i_tbl_base};

    sat_table u_table (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_we(i_tbl_we), // [RULE5]
        .i_waddr(i_tbl_idx),
        .i_wdata(wr_ent),
        .i_raddr(i_seg[`SAT_IDX_W-1:0]), // [RULE1]
        .o_rdata(ent)
    );

    assign ent_base = ent[`SAT_ENT_BASE_MSB:`SAT_ENT_BASE_LSB];
    assign ent_lim = ent[`SAT_ENT_LIM_MSB:`SAT_ENT_LIM_LSB];
    // limit holds size in 256-byte pages minus one, so 0 is 256 B and FF is 64 KB
    assign over_lim = s1_ofs[`SAT_OFS_W-1:`SAT_PAGE_LSB] > ent_lim; // [RULE4] [RULE11]
    assign attr_bad = (ent[`SAT_ENT_WP] & s1_write) // [RULE6]
        | (ent[`SAT_ENT_SYS] & ~s1_sys) // [RULE7]
        | (ent[`SAT_ENT_EXO] & ~s1_code); // [RULE7]
    assign bad = ~ent[`SAT_ENT_VAL] | over_lim | attr_bad; // [RULE11]
    // base is a 256-byte multiple; add, do not concatenate
    assign next_phys = {ent_base, `SAT_ZERO8} + {`SAT_ZERO8, s1_ofs}; // [RULE2] [RULE10]

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            s1_req <= 1'b0;
            s1_mine <= 1'b0;
            s1_ofs <= {`SAT_OFS_W{1'b0}};
            s1_write <= 1'b0;
            s1_sys <= 1'b0;
            s1_code <= 1'b0;
            o_mem_req <= 1'b0;
            o_mem_write <= 1'b0;
            o_phys_addr <= `SAT_PHY_RST;
            o_violation <= 1'b0;
            o_hit <= 1'b0;
        end else if (i_ce) begin
            s1_req <= i_req;
            s1_mine <= mine;
            s1_ofs <= i_ofs;
            s1_write <= i_write;
            s1_sys <= i_sys_space;
            s1_code <= i_code_space;
            o_hit <= s1_req & s1_mine;
            o_mem_req <= s1_req & s1_mine & ~bad; // [RULE6] [RULE11]
            o_mem_write <= s1_req & s1_mine & ~bad & s1_write;
            o_violation <= s1_req & s1_mine & bad; // [RULE11]
            if (s1_req & s1_mine) begin
                o_phys_addr <= next_phys;
            end
        end
    end
endmodule // sat_translator

// ===== verif/sat_mem_model.sv
// physical memory side: remembers the last granted access
`timescale 1ns/10ps
module sat_mem_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic [23:0] i_addr,
    output logic [23:0] o_last,
    output logic o_wr
);
    // only granted accesses ever reach memory, so denied ones leave o_last alone
    always @(posedge i_clk) if (i_req) begin
        o_last <= i_addr;
        o_wr <= i_wr;
    end
endmodule // sat_mem_model

// ===== verif/sat_chk.sv
// assertions on the translator ports
`timescale 1ns/10ps
module sat_chk (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req,
    input wire logic o_mem_req,
    input wire logic o_mem_write,
    input wire logic o_violation,
    input wire logic o_hit
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence answer_s; o_mem_req || o_violation; endsequence
    one_way_a: assert property (!(o_mem_req && o_violation)) else $error("grant and deny");
    owned_a: assert property (answer_s |-> o_hit) else $error("answer without hit");
    write_gate_a: assert property (o_mem_write |-> o_mem_req) else $error("bad write");
    hit_cause_a: assert property (o_hit |-> $past(i_req, 2)) else $error("stray hit");
    hit_answer_a: assert property (o_hit |-> answer_s) else $error("hit without answer");
    deny_nowrite_a: assert property (o_violation |-> !o_mem_write) else $error("denied write");
    reset_quiet_a: assert property ($past(i_sys_rst) |-> !answer_s) else $error("answer after reset");
endmodule // sat_chk

// ===== verif/sat_translator_tb_top.sv
// testbench for the segment address translator
`timescale 1ns/10ps
`define CK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module sat_translator_tb_top;
    logic i_clk = 0, i_sys_rst = 1, rq = 0, wr = 0, sy = 0, cd = 0, we = 0, wp = 0, so = 0;
    logic xo = 0, vl = 0, ce = 1, mreq, mwr, vio, hit, h, v, m, lw;
    logic [6:0] sg = 0;
    logic [15:0] of = 0, bs = 0;
    logic [5:0] ix = 0;
    logic [7:0] lm = 0;
    logic [23:0] pa, la;
    int mismatches = 0, compares = 0;
    sat_translator i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_unit_group(1'b0),
        .i_req(rq), .i_seg(sg), .i_ofs(of), .i_write(wr), .i_sys_space(sy), .i_code_space(cd),
        .i_tbl_we(we), .i_tbl_idx(ix), .i_tbl_base(bs), .i_tbl_limit(lm), .i_tbl_wprot(wp),
        .i_tbl_sys_only(so), .i_tbl_exec_only(xo), .i_tbl_valid(vl), .o_mem_req(mreq),
        .o_mem_write(mwr), .o_phys_addr(pa), .o_violation(vio), .o_hit(hit));
    sat_mem_model i_mem (.i_clk(i_clk), .i_req(mreq), .i_wr(mwr), .i_addr(pa), .o_last(la),
        .o_wr(lw));
    initial forever #10 i_clk = ~i_clk;
    task tw(input [5:0] i, input [15:0] b, input [7:0] l, input [3:0] a);
        @(negedge i_clk); we = 1; ix = i; bs = b; lm = l; {vl, xo, so, wp} = a;
        @(negedge i_clk); we = 0;
    endtask
    // e is {hit, denied, granted}; pulses are gathered over a fixed answer window
    task tr(input [6:0] s, input [15:0] o, input [2:0] q, input [2:0] e, input [23:0] ea);
        @(negedge i_clk); rq = 1; sg = s; of = o; {wr, sy, cd} = q; {h, v, m} = 3'h0;
        repeat (4) begin @(negedge i_clk); rq = 0; h |= hit; v |= vio; m |= mreq; end
        `CK("hit deny grant", e, {h, v, m})
        if (m) `CK("memory address", ea, la)
    endtask
    task t_add;
        tw(6'h00, 16'h0123, 8'hFF, 4'h8);
        tr(7'h00, 16'hFFFF, 3'h0, 3'h5, 24'h0222FF);
        tr(7'h00, 16'h0010, 3'h4, 3'h5, 24'h012310);
        `CK("write flag", 1'b1, lw)
    endtask
    task t_prot;
        tw(6'h01, 16'h0200, 8'hFF, 4'h9); tw(6'h02, 16'h0200, 8'hFF, 4'hA);
        tw(6'h03, 16'h0200, 8'hFF, 4'hC); tw(6'h05, 16'h0200, 8'hFF, 4'h0);
        tr(7'h01, 16'h0004, 3'h4, 3'h6, 24'h0);
        tr(7'h02, 16'h0004, 3'h0, 3'h6, 24'h0);
        tr(7'h02, 16'h0004, 3'h2, 3'h5, 24'h020004);
        tr(7'h03, 16'h0004, 3'h0, 3'h6, 24'h0);
        tr(7'h03, 16'h0006, 3'h1, 3'h5, 24'h020006);
        tr(7'h05, 16'h0004, 3'h0, 3'h6, 24'h0);
    endtask
    task t_lim;
        tw(6'h04, 16'h0100, 8'h01, 4'h8);
        tr(7'h04, 16'h01FF, 3'h0, 3'h5, 24'h0101FF);
        tr(7'h04, 16'h0200, 3'h0, 3'h6, 24'h0);
        tr(7'h44, 16'h0000, 3'h0, 3'h0, 24'h0);
        tw(6'h04, 16'h0300, 8'hFF, 4'h8);
        tr(7'h04, 16'h0205, 3'h0, 3'h5, 24'h030205);
    endtask
    // a request offered while the clock enable is low must never be taken
    task t_ce;
        @(negedge i_clk); ce = 0; rq = 1; sg = 7'h00; of = 16'h0010; {wr, sy, cd} = 3'h0; h = 0;
        repeat (3) begin @(negedge i_clk); h |= hit | mreq | vio; end
        ce = 1; rq = 0;
        repeat (3) begin @(negedge i_clk); h |= hit | mreq | vio; end
        `CK("frozen request", 1'b0, h)
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        @(negedge i_clk) i_sys_rst = 0;
        t_add; t_prot; t_lim; t_ce;
        end_of_test;
    end
    initial begin #100000; mismatches++; end_of_test; end
endmodule // sat_translator_tb_top
bind sat_translator sat_chk i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
    .o_mem_req(o_mem_req), .o_mem_write(o_mem_write), .o_violation(o_violation), .o_hit(o_hit));
